// >>> hw/ltid_defines.svh
// Opcode fields and cycle counts for the literal and table instruction decoder.
// Assumes 16-bit instruction words as fetched from program memory.
`ifndef LTID_DEFINES_SVH
`define LTID_DEFINES_SVH
`define LTID_GRP_LIT 4'h0
`define LTID_GRP_PTR 4'he
`define LTID_GRP_EXT 4'hf
`define LTID_SUB_ADD 4'hf
`define LTID_SUB_AND 4'hb
`define LTID_SUB_OR 4'h9
`define LTID_SUB_XOR 4'ha
`define LTID_SUB_SUB 4'h8
`define LTID_SUB_LOAD 4'he
`define LTID_SUB_MUL 4'hd
`define LTID_SUB_RET 4'hc
`define LTID_SUB_MISC 4'h0
`define LTID_SUB_BANK 4'h1
`define LTID_PSUB_ADD 4'h8
`define LTID_PSUB_SUB 4'h9
`define LTID_PSUB_LOAD 4'he
`define LTID_TBL_RD 2'h2
`define LTID_TBL_WT 2'h3
`define LTID_CYC_ONE 3'h1
`define LTID_CYC_TWO 3'h2
`define LTID_CYC_TBL_MAX 3'h5
`define LTID_BANK_FORCE 2'h0
`endif

// >>> hw/ltid_pkg.sv
// Types shared by the instruction decoder.
// Assumes nothing beyond the defines header.
package ltid_pkg;
    typedef enum logic [3:0] {
        LTID_NOP, LTID_ADD, LTID_AND, LTID_OR, LTID_XOR, LTID_SUBL, LTID_LOAD, LTID_MUL,
        LTID_RET, LTID_BANK, LTID_PLOAD, LTID_PADD, LTID_PSUB, LTID_TABLE_READ_OP, LTID_TABLE_WRITE_OP,
        LTID_ILLEGAL
    } ltid_op_t;
    typedef enum logic [1:0] {
        LTID_TBL_KEEP, LTID_TBL_POSTINC, LTID_TBL_POSTDEC, LTID_TBL_PREINC
    } ltid_tbl_t;
endpackage

// >>> hw/ltid_decoder.sv
// Decoder for literal, pointer and table instructions of an 8-bit core.
// Assumes one fetched word per valid strobe, and that the datapath reports
// program counter changes, true conditions and table completion.
// Operation
// - 0000 1111 k adds literal to working register, one cycle, C DC Z OV N.
// - 0000 1011 k ANDs literal with working register, one cycle, Z N.
// - 0000 1001 k ORs literal into working register, one cycle, Z N.
// - 0000 1010 k XORs literal with working register, one cycle, Z N.
// - 0000 1000 k subtracts working register from literal, one cycle, all flags.
// - 0000 1110 k loads literal into working register, one cycle, no flags.
// - 0000 1101 k multiplies literal by working register, one cycle, no flags.
// - 0000 1100 k returns with literal in working register, two cycles.
// - 0000 0001 00kk kkkk loads six-bit literal into bank select bits five-zero.
// - Two-word pointer load of a 14-bit literal, two cycles, no flags.
// - 1110 1000 ffkk kkkk adds six-bit literal to selected pointer.
// - 1110 1001 ffkk kkkk subtracts six-bit literal from selected pointer.
// - 0000 0000 0000 10xx table read, 2 to 5 cycles, xx selects pointer mode.
// - 0000 0000 0000 11xx table write, 2 to 5 cycles, xx selects pointer mode.
// - Program counter change or true condition adds one no-operation cycle.
// - Stray extension words (1111) decode as no-operation unless consumed as operand.
// - Register move source and destination fields get upper bank bits forced zero.
`timescale 1ns/1ps
`include "ltid_defines.svh"
module ltid_decoder
    import ltid_pkg::*;
#(
    parameter int WORD_W = 16,
    parameter int MOVE_ADDR_W = 14
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic instr_valid,
    input wire logic [WORD_W-1:0] instr_word,
    input wire logic pc_changed,
    input wire logic cond_true,
    input wire logic table_done,
    input wire logic [MOVE_ADDR_W-1:0] move_src_addr,
    input wire logic [MOVE_ADDR_W-1:0] move_dst_addr,
    output ltid_op_t op,
    output logic op_valid,
    output logic [7:0] literal,
    output logic [13:0] pointer_literal,
    output logic [1:0] pointer_sel,
    output ltid_tbl_t table_mode,
    output logic [2:0] cycles,
    output logic [4:0] flag_update,
    output logic extra_nop,
    output logic busy,
    output logic [MOVE_ADDR_W-1:0] move_src_limited,
    output logic [MOVE_ADDR_W-1:0] move_dst_limited
);
    // The decode tables assume 16-bit words, and the bank forcing needs at least
    // three address bits to leave anything below the two forced ones.
    if (WORD_W != 16 || MOVE_ADDR_W < 3) begin : g_bad_params
        $error("ltid_decoder: unsupported parameter values");
    end

    // Flag order in flag_update is {N, OV, Z, DC, C}.
    localparam logic [4:0] FLAGS_ALL = 5'h1f;
    localparam logic [4:0] FLAGS_ZN = 5'h14;
    localparam logic [4:0] FLAGS_NONE = 5'h00;

    typedef enum logic [1:0] {LTID_S_FIRST, LTID_S_SECOND, LTID_S_TABLE} ltid_state_t;
    ltid_state_t state;
    logic [1:0] held_sel;
    logic [3:0] held_hi;
    logic [2:0] tbl_count;

    function automatic ltid_op_t ltid_classify(input logic [15:0] w);
        ltid_op_t r;
        r = LTID_ILLEGAL;
        unique case (w[15:12])
            `LTID_GRP_LIT: begin
                unique case (w[11:8])
                    `LTID_SUB_ADD: r = LTID_ADD;
                    `LTID_SUB_AND: r = LTID_AND;
                    `LTID_SUB_OR: r = LTID_OR;
                    `LTID_SUB_XOR: r = LTID_XOR;
                    `LTID_SUB_SUB: r = LTID_SUBL;
                    `LTID_SUB_LOAD: r = LTID_LOAD;
                    `LTID_SUB_MUL: r = LTID_MUL;
                    `LTID_SUB_RET: r = LTID_RET;
                    `LTID_SUB_BANK: r = (w[7:6] == 2'h0) ? LTID_BANK : LTID_ILLEGAL;
                    `LTID_SUB_MISC: begin
                        if (w[7:4] == 4'h0 && w[3:2] == `LTID_TBL_RD) begin
                            r = LTID_TABLE_READ_OP;
                        end else if (w[7:4] == 4'h0 && w[3:2] == `LTID_TBL_WT) begin
                            r = LTID_TABLE_WRITE_OP;
                        end else if (w[7:0] == 8'h00) begin
                            r = LTID_NOP;
                        end
                    end
                    default: r = LTID_ILLEGAL;
                endcase
            end
            `LTID_GRP_PTR: begin
                unique case (w[11:8])
                    `LTID_PSUB_ADD: r = LTID_PADD;
                    `LTID_PSUB_SUB: r = LTID_PSUB;
                    `LTID_PSUB_LOAD: r = (w[7:6] == 2'h0) ? LTID_PLOAD : LTID_ILLEGAL;
                    default: r = LTID_ILLEGAL;
                endcase
            end
            // A stray extension word outside a pointer load runs as a no-operation.
            `LTID_GRP_EXT: r = LTID_NOP;
            default: r = LTID_ILLEGAL;
        endcase
        return r;
    endfunction

    function automatic logic [4:0] ltid_flags(input ltid_op_t o);
        unique case (o)
            LTID_ADD, LTID_SUBL: return FLAGS_ALL;
            LTID_AND, LTID_OR, LTID_XOR: return FLAGS_ZN;
            default: return FLAGS_NONE;
        endcase
    endfunction

    function automatic logic ltid_is_table(input ltid_op_t o);
        return o == LTID_TABLE_READ_OP || o == LTID_TABLE_WRITE_OP;
    endfunction

    ltid_op_t dec_op;
    assign dec_op = ltid_classify(instr_word);

    // Sequencing: pointer load waits for its operand word; table ops wait for done or the five-cycle ceiling.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            state <= LTID_S_FIRST;
            held_sel <= 2'h0;
            held_hi <= 4'h0;
            tbl_count <= 3'h0;
        end else begin
            unique case (state)
                LTID_S_FIRST: begin
                    if (instr_valid && dec_op == LTID_PLOAD) begin
                        state <= LTID_S_SECOND;
                        held_sel <= instr_word[5:4];
                        held_hi <= instr_word[3:0];
                    end else if (instr_valid && ltid_is_table(dec_op)) begin
                        state <= LTID_S_TABLE;
                        tbl_count <= `LTID_CYC_ONE;
                    end
                end
                LTID_S_SECOND: begin
                    if (instr_valid) begin
                        state <= LTID_S_FIRST;
                    end
                end
                LTID_S_TABLE: begin
                    // The table access ends on done, or at the five-cycle ceiling.
                    if (table_done || tbl_count == `LTID_CYC_TBL_MAX - 3'h1) begin
                        state <= LTID_S_FIRST;
                    end
                    tbl_count <= tbl_count + 3'h1;
                end
            endcase
        end
    end

    // Decoded controls, registered so the datapath sees clean flip-flop outputs.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            op <= LTID_NOP;
            op_valid <= 1'b0;
            literal <= 8'h00;
            pointer_literal <= 14'h0000;
            pointer_sel <= 2'h0;
            table_mode <= LTID_TBL_KEEP;
            cycles <= `LTID_CYC_ONE;
            flag_update <= FLAGS_NONE;
        end else begin
            op_valid <= 1'b0;
            if (instr_valid && state == LTID_S_SECOND) begin
                op_valid <= 1'b1;
                flag_update <= FLAGS_NONE;
                if (instr_word[15:12] == `LTID_GRP_EXT && instr_word[11:10] == 2'h0) begin
                    op <= LTID_PLOAD;
                    pointer_sel <= held_sel;
                    pointer_literal <= {held_hi, instr_word[9:0]};
                    cycles <= `LTID_CYC_TWO;
                end else begin
                    op <= LTID_ILLEGAL;
                    cycles <= `LTID_CYC_ONE;
                end
            end else if (instr_valid && state == LTID_S_FIRST && dec_op != LTID_PLOAD) begin
                op_valid <= 1'b1;
                op <= dec_op;
                literal <= (dec_op == LTID_BANK) ? {2'h0, instr_word[5:0]} : instr_word[7:0];
                if (dec_op == LTID_PADD || dec_op == LTID_PSUB) begin
                    pointer_sel <= instr_word[7:6];
                    pointer_literal <= {8'h00, instr_word[5:0]};
                end
                table_mode <= ltid_tbl_t'(instr_word[1:0]);
                flag_update <= ltid_flags(dec_op);
                if (dec_op == LTID_RET || ltid_is_table(dec_op)) begin
                    cycles <= `LTID_CYC_TWO;
                end else begin
                    cycles <= `LTID_CYC_ONE;
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            extra_nop <= 1'b0;
            busy <= 1'b0;
        end else begin
            extra_nop <= pc_changed || cond_true;
            busy <= (state != LTID_S_FIRST && !(state == LTID_S_SECOND && instr_valid))
                || (state == LTID_S_FIRST && instr_valid
                    && (dec_op == LTID_PLOAD || ltid_is_table(dec_op)));
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            move_src_limited <= '0;
            move_dst_limited <= '0;
        end else begin
            move_src_limited <= {`LTID_BANK_FORCE, move_src_addr[MOVE_ADDR_W-3:0]};
            move_dst_limited <= {`LTID_BANK_FORCE, move_dst_addr[MOVE_ADDR_W-3:0]};
        end
    end

    a_flags_add_sub: assert property (@(posedge clk_sys) disable iff (!rstn)
        instr_valid && state == LTID_S_FIRST && (dec_op == LTID_ADD || dec_op == LTID_SUBL)
        |=> op_valid && flag_update == 5'h1f && cycles == 3'h1)
        else $error("add or subtract literal decoded wrongly");
    a_sub_literal: assert property (@(posedge clk_sys) disable iff (!rstn)
        instr_valid && state == LTID_S_FIRST && instr_word[15:8] == 8'h08
        |=> op == LTID_SUBL && literal == $past(instr_word[7:0]))
        else $error("subtract from literal decoded wrongly");
    a_flags_logic_ops: assert property (@(posedge clk_sys) disable iff (!rstn)
        instr_valid && state == LTID_S_FIRST && instr_word[15:8] inside {8'h0b, 8'h09, 8'h0a}
        |=> flag_update == 5'h14 && op inside {LTID_AND, LTID_OR, LTID_XOR})
        else $error("logic literal op flags wrong");
    a_or_literal: assert property (@(posedge clk_sys) disable iff (!rstn)
        instr_valid && state == LTID_S_FIRST && instr_word[15:8] == 8'h09
        |=> op == LTID_OR && cycles == 3'h1 && literal == $past(instr_word[7:0]))
        else $error("or literal decoded wrongly");
    a_xor_literal: assert property (@(posedge clk_sys) disable iff (!rstn)
        instr_valid && state == LTID_S_FIRST && instr_word[15:8] == 8'h0a
        |=> op == LTID_XOR && cycles == 3'h1 && literal == $past(instr_word[7:0]))
        else $error("xor literal decoded wrongly");
    a_load_mul_flags: assert property (@(posedge clk_sys) disable iff (!rstn)
        instr_valid && state == LTID_S_FIRST && instr_word[15:8] inside {8'h0e, 8'h0d}
        |=> op inside {LTID_LOAD, LTID_MUL} && flag_update == 5'h00 && cycles == 3'h1
            && literal == $past(instr_word[7:0]))
        else $error("load or multiply literal decoded wrongly");
    a_mul_literal: assert property (@(posedge clk_sys) disable iff (!rstn)
        instr_valid && state == LTID_S_FIRST && instr_word[15:8] == 8'h0d
        |=> op == LTID_MUL && flag_update == 5'h00)
        else $error("multiply literal decoded wrongly");
    a_ret_two_cycles: assert property (@(posedge clk_sys) disable iff (!rstn)
        instr_valid && state == LTID_S_FIRST && instr_word[15:8] == 8'h0c
        |=> op == LTID_RET && cycles == 3'h2 && flag_update == 5'h00
            && literal == $past(instr_word[7:0]))
        else $error("return with literal decoded wrongly");
    a_bank_literal: assert property (@(posedge clk_sys) disable iff (!rstn)
        instr_valid && state == LTID_S_FIRST && instr_word[15:6] == 10'h004
        |=> op == LTID_BANK && literal[7:6] == 2'h0
            && literal[5:0] == $past(instr_word[5:0]))
        else $error("bank literal decoded wrongly");
    a_pointer_load_pair: assert property (@(posedge clk_sys) disable iff (!rstn)
        instr_valid && state == LTID_S_FIRST && instr_word[15:6] == 10'h3b8 ##1
        instr_valid && instr_word[15:10] == 6'h3c
        |=> op == LTID_PLOAD && cycles == 3'h2
            && pointer_literal[9:0] == $past(instr_word[9:0]))
        else $error("pointer load not paired");
    a_pload_waits: assert property (@(posedge clk_sys) disable iff (!rstn)
        instr_valid && state == LTID_S_FIRST && instr_word[15:6] == 10'h3b8
        |=> busy && !op_valid)
        else $error("pointer load first word answered too early");
    a_pointer_add_sub: assert property (@(posedge clk_sys) disable iff (!rstn)
        instr_valid && state == LTID_S_FIRST && instr_word[15:9] == 7'h74
        |=> op inside {LTID_PADD, LTID_PSUB} && pointer_sel == $past(instr_word[7:6])
            && pointer_literal == {8'h00, $past(instr_word[5:0])})
        else $error("pointer add or subtract decoded wrongly");
    a_pointer_sub: assert property (@(posedge clk_sys) disable iff (!rstn)
        instr_valid && state == LTID_S_FIRST && instr_word[15:8] == 8'he9
        |=> op == LTID_PSUB && flag_update == 5'h00 && cycles == 3'h1)
        else $error("pointer subtract decoded wrongly");
    a_table_mode: assert property (@(posedge clk_sys) disable iff (!rstn)
        instr_valid && state == LTID_S_FIRST && instr_word[15:3] == 13'h0001
        |=> op_valid && table_mode == ltid_tbl_t'($past(instr_word[1:0])) ##1 busy)
        else $error("table access decoded wrongly");
    a_table_write: assert property (@(posedge clk_sys) disable iff (!rstn)
        instr_valid && state == LTID_S_FIRST && instr_word[15:2] == 14'h0003
        |=> op == LTID_TABLE_WRITE_OP && cycles == 3'h2 && flag_update == 5'h00)
        else $error("table write decoded wrongly");
    a_table_quiet: assert property (@(posedge clk_sys) disable iff (!rstn)
        state == LTID_S_TABLE |=> !op_valid)
        else $error("word decoded during a table access");
    a_table_bound: assert property (@(posedge clk_sys) disable iff (!rstn)
        state == LTID_S_TABLE && tbl_count == 3'h4 |=> state == LTID_S_FIRST)
        else $error("table access exceeded five cycles");
    a_extra_nop: assert property (@(posedge clk_sys) disable iff (!rstn)
        (pc_changed || cond_true) |=> extra_nop)
        else $error("extra cycle not flagged");
    a_extra_nop_clear: assert property (@(posedge clk_sys) disable iff (!rstn)
        !(pc_changed || cond_true) |=> !extra_nop)
        else $error("extra cycle flagged without cause");
    a_stray_ext_nop: assert property (@(posedge clk_sys) disable iff (!rstn)
        instr_valid && state == LTID_S_FIRST && instr_word[15:12] == 4'hf
        |=> op == LTID_NOP)
        else $error("stray extension word not a no-operation");
    a_second_word_bad: assert property (@(posedge clk_sys) disable iff (!rstn)
        instr_valid && state == LTID_S_SECOND && instr_word[15:10] != 6'h3c
        |=> op_valid && op == LTID_ILLEGAL)
        else $error("bad pointer load operand word accepted");
    a_bank_forced: assert property (@(posedge clk_sys) disable iff (!rstn)
        $past(rstn) |-> move_src_limited[MOVE_ADDR_W-1 -: 2] == 2'h0
            && move_dst_limited[MOVE_ADDR_W-1 -: 2] == 2'h0
            && move_src_limited[MOVE_ADDR_W-3:0] == $past(move_src_addr[MOVE_ADDR_W-3:0]))
        else $error("move operand bank bits not forced");
    a_op_valid_cause: assert property (@(posedge clk_sys) disable iff (!rstn)
        op_valid |-> $past(instr_valid) && $past(state) != LTID_S_TABLE)
        else $error("decode strobe without a taken word");
endmodule

// >>> tb/ltid_fetch_model.sv
// Behavioural program memory fetch and datapath partner for the instruction decoder.
// Assumes the bench calls present just after a rising clock edge.
`timescale 1ns/1ps
module ltid_fetch_model (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [3:0] tbl_delay,
    output logic instr_valid,
    output logic [15:0] instr_word,
    output logic table_done
);
    logic [3:0] wait_cnt;
    logic waiting;
    logic took;
    initial begin
        instr_valid = 1'b0;
        instr_word = 16'h5a5a;
        table_done = 1'b0;
        waiting = 1'b0;
        wait_cnt = 4'h0;
    end
    // The word stands for exactly one taking edge; afterwards the bus is inverted so a
    // stale word can never pass for a fresh one. Keep leaves valid and the word up for
    // the next call, so no signal is driven twice in one time step.
    task automatic present(input logic [15:0] w, input logic keep);
        instr_valid = 1'b1;
        instr_word = w;
        @(posedge clk_sys);
        #1;
        if (!keep) begin
            instr_valid = 1'b0;
            instr_word = ~w;
        end
    endtask
    // Completion comes tbl_delay cycles after the table word is taken, so slow memories
    // beyond the decoder's ceiling can be imitated as well as prompt ones.
    always @(posedge clk_sys) begin
        took = instr_valid && (instr_word[15:3] == 13'h0001);
        #1;
        table_done = 1'b0;
        if (!rstn) begin
            waiting = 1'b0;
        end else if (took) begin
            waiting = 1'b1;
            wait_cnt = tbl_delay;
        end else if (waiting) begin
            wait_cnt = wait_cnt - 4'h1;
            if (wait_cnt == 4'h0) begin
                table_done = 1'b1;
                waiting = 1'b0;
            end
        end
    end
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the literal, pointer and table instruction decoder.
// Assumes the fetch model drives words and table completion; the bench drives the rest.
`timescale 1ns/1ps
module testbench;
    import ltid_pkg::*;
    logic clk_sys, rstn, pc_changed, cond_true, instr_valid, table_done;
    logic [3:0] tbl_delay;
    logic [15:0] instr_word;
    logic [13:0] move_src_addr, move_dst_addr, move_src_limited, move_dst_limited;
    ltid_op_t op;
    ltid_tbl_t table_mode;
    logic op_valid, extra_nop, busy;
    logic [7:0] literal;
    logic [13:0] pointer_literal;
    logic [1:0] pointer_sel;
    logic [2:0] cycles;
    logic [4:0] flag_update;
    int fail_count, check_count;
    ltid_fetch_model fetch (.clk_sys(clk_sys), .rstn(rstn), .tbl_delay(tbl_delay),
        .instr_valid(instr_valid), .instr_word(instr_word), .table_done(table_done));
    ltid_decoder dut (.clk_sys(clk_sys), .rstn(rstn), .instr_valid(instr_valid),
        .instr_word(instr_word), .pc_changed(pc_changed), .cond_true(cond_true),
        .table_done(table_done), .move_src_addr(move_src_addr), .move_dst_addr(move_dst_addr),
        .op(op), .op_valid(op_valid), .literal(literal), .pointer_literal(pointer_literal),
        .pointer_sel(pointer_sel), .table_mode(table_mode), .cycles(cycles),
        .flag_update(flag_update), .extra_nop(extra_nop), .busy(busy),
        .move_src_limited(move_src_limited), .move_dst_limited(move_dst_limited));
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("checks=%0d mismatches=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // All eight literal operations back to back, so no idle cycle hides a stale field.
    task automatic t_literal();
        ltid_op_t lops[8] = '{LTID_ADD, LTID_AND, LTID_OR, LTID_XOR, LTID_SUBL, LTID_LOAD,
            LTID_MUL, LTID_RET};
        logic [3:0] lsub[8] = '{4'hf, 4'hb, 4'h9, 4'ha, 4'h8, 4'he, 4'hd, 4'hc};
        logic [4:0] lflg[8] = '{5'h1f, 5'h14, 5'h14, 5'h14, 5'h1f, 5'h00, 5'h00, 5'h00};
        logic [7:0] k;
        for (int i = 0; i < 8; i++) begin
            k = 8'ha5 ^ 8'(i * 17);
            fetch.present({4'h0, lsub[i], k}, i != 7);
            if (i < 4) begin
                chk(16'(op), 16'(lops[i]));
                chk(16'(flag_update), 16'(lflg[i]));
            end else begin
                chk(16'(op), 16'(lops[i]));
                chk(16'(flag_update), 16'(lflg[i]));
            end
            chk({15'h0, op_valid}, 16'h1);
            chk({8'h0, literal}, {8'h0, k});
            chk({13'h0, cycles}, (i == 7) ? 16'h2 : 16'h1);
        end
        $display("test literal done");
    endtask
    task automatic t_bank_pointer();
        fetch.present(16'h0125, 1'b0);
        chk(16'(op), 16'(LTID_BANK));
        chk({8'h0, literal}, 16'h0025);
        chk({11'h0, flag_update}, 16'h0);
        @(posedge clk_sys);
        #1;
        chk({15'h0, op_valid}, 16'h0);
        fetch.present(16'he8ab, 1'b1);
        chk(16'(op), 16'(LTID_PADD));
        chk({14'h0, pointer_sel}, 16'h2);
        chk({2'h0, pointer_literal}, 16'h002b);
        fetch.present(16'he9c5, 1'b0);
        chk(16'(op), 16'(LTID_PSUB));
        chk({14'h0, pointer_sel}, 16'h3);
        chk({2'h0, pointer_literal}, 16'h0005);
        chk({11'h0, flag_update}, 16'h0);
        $display("test bank and pointer done");
    endtask
    task automatic t_pload();
        fetch.present(16'hee1a, 1'b1);
        chk({15'h0, busy}, 16'h1);
        chk({15'h0, op_valid}, 16'h0);
        fetch.present(16'hf0ff, 1'b1);
        chk(16'(op), 16'(LTID_PLOAD));
        chk({14'h0, pointer_sel}, 16'h1);
        chk({2'h0, pointer_literal}, 16'h28ff);
        chk({13'h0, cycles}, 16'h2);
        chk({15'h0, busy}, 16'h0);
        fetch.present(16'hf123, 1'b1);
        chk(16'(op), 16'(LTID_NOP));
        fetch.present(16'hee00, 1'b1);
        fetch.present(16'h0f12, 1'b0);
        chk(16'(op), 16'(LTID_ILLEGAL));
        $display("test pointer load done");
    endtask
    // Each pointer mode of read and write; the last one of each stalls past the ceiling.
    task automatic t_table();
        int n;
        for (int i = 0; i < 8; i++) begin
            tbl_delay = ((i % 4) == 3) ? 4'h8 : 4'(i % 4 + 1);
            fetch.present(16'h0008 | 16'(i), 1'b0);
            chk(16'(op), (i < 4) ? 16'(LTID_TABLE_READ_OP) : 16'(LTID_TABLE_WRITE_OP));
            chk({14'h0, table_mode}, 16'(i % 4));
            chk({13'h0, cycles}, 16'h2);
            chk({11'h0, flag_update}, 16'h0);
            // A word offered while the access is stalled must be ignored.
            if (i % 4 == 3) begin
                fetch.present(16'h0e77, 1'b0);
                chk({15'h0, op_valid}, 16'h0);
            end
            n = 0;
            while (busy === 1'b1 && n < 6) begin
                @(posedge clk_sys);
                #1;
                n++;
            end
            chk({15'h0, busy}, 16'h0);
            if (busy !== 1'b0) begin
                test_done();
            end
            chk(16'(n), (i % 4 == 3) ? 16'h4 : 16'(i % 4 + 3));
        end
        $display("test table done");
    endtask
    task automatic t_side();
        logic [13:0] s;
        for (int c = 0; c < 5; c++) begin
            s = 14'h3fff ^ 14'(c * 14'h1111);
            pc_changed = c[0];
            cond_true = c[1];
            move_src_addr = s;
            move_dst_addr = ~s;
            @(posedge clk_sys);
            #1;
            chk({15'h0, extra_nop}, {15'h0, c[0] | c[1]});
            chk({2'h0, move_src_limited}, {4'h0, s[11:0]});
            chk({2'h0, move_dst_limited}, {4'h0, ~s[11:0]});
        end
        $display("test side outputs done");
    endtask
    initial begin
        fail_count = 0;
        check_count = 0;
        rstn = 1'b0;
        pc_changed = 1'b0;
        cond_true = 1'b0;
        tbl_delay = 4'h1;
        move_src_addr = 14'h0;
        move_dst_addr = 14'h0;
        repeat (4) @(posedge clk_sys);
        #1;
        rstn = 1'b1;
        chk(16'(op), 16'(LTID_NOP));
        chk({13'h0, cycles}, 16'h1);
        t_literal();
        t_bank_pointer();
        t_pload();
        t_table();
        t_side();
        test_done();
    end
endmodule
